// ===== test/lin_node_model.sv
// lin_node_model.sv: remote bus nodes and the pull-up on the single wire
// assumes the bench commands dominant bits through pull_dom
module lin_node_model (
   input wire logic clock, // system clock
   input wire logic pull_dom, // remote node sends dominant
   input wire logic drv_oe, // design pulls the wire
   input wire logic drv_out, // design drive level
   output logic level // resolved bus level, low is dominant
);
   timeunit 1ns;
   timeprecision 100ps;
   logic node_reg = 1'h0;
   // remote driver answers one cycle after its command
   always @(posedge clock) begin
      node_reg <= pull_dom;
   end
   // wire-and with pull-up: a released wire goes recessive, never stale
   assign level = !((drv_oe && !drv_out) || node_reg);
endmodule

// ===== test/tb_lin_transceiver_mode_control.sv
// tb_lin_transceiver_mode_control.sv: self-checking bench for lin_ctrl
// assumes the map header on the include path; short enabling and wake times
`include "lin_ctrl_map.svh"
module tb_lin_transceiver_mode_control;
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // signals, table and instances
   // ************************************************************
   typedef struct {
      logic [2:0] dev;
      logic [1:0] first;
      logic [1:0] second;
      logic [1:0] exp;
   } row_t;
   logic clock = 1'h0;
   logic reset_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, err, bus_rx_output, lin_bus_out, lin_bus_oe, bus_level;
   logic [2:0] device_mode = 3'h0;
   logic bus_tx_input = 1'h1;
   logic pull_dom = 1'h0;
   int fails = 0;
   int comparisons = 0;
   int n;
   // device mode, two mode writes, mode read back
   row_t rows [9] = '{'{3'h0, 2'h3, 2'h2, 2'h2}, '{3'h0, 2'h2, 2'h3, 2'h3},
      '{3'h1, 2'h2, 2'h3, 2'h2}, '{3'h1, 2'h1, 2'h0, 2'h0}, '{3'h2, 2'h1, 2'h3, 2'h1},
      '{3'h3, 2'h1, 2'h2, 2'h1}, '{3'h4, 2'h1, 2'h2, 2'h0}, '{3'h4, 2'h0, 2'h3, 2'h0},
      '{3'h2, 2'h2, 2'h0, 2'h0}};
   // short times keep the enabling window at 10 cycles
   lin_ctrl #(.EN_TIME_NS(100), .WAKE_TIME_NS(100), .FIFO_DEPTH(32)) DUT (
      .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .device_mode(device_mode), .bus_tx_input(bus_tx_input), .bus_rx_output(bus_rx_output),
      .lin_bus_in(bus_level), .lin_bus_out(lin_bus_out), .lin_bus_oe(lin_bus_oe));
   lin_node_model partner (.clock(clock), .pull_dom(pull_dom), .drv_oe(lin_bus_oe),
      .drv_out(lin_bus_out), .level(bus_level));
   // 100 MHz clock
   always #5 clock = ~clock;
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic chk1(input string name, input logic exp, input logic got);
      chk(name, {31'h0, exp}, {31'h0, got});
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(name, exp, rd & m);
   endtask
   // remote dominant well past the wake time, then recessive
   task automatic wake_pulse;
      pull_dom <= 1'h1;
      cyc(20);
      pull_dom <= 1'h0;
      cyc(5);
   endtask
   task automatic test_done;
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      cyc(20000);
      fails++;
      test_done();
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      cyc(12);
      reset_n <= 1'h1;
      chk1("oe after reset", 1'h0, lin_bus_oe);
      chk1("rx after reset", 1'h1, bus_rx_output);
      rd_chk("mode after reset", `REG_MODE_CTRL, 32'h3, 32'h0);
      // off: host low and a wake pattern must both be ignored
      bus_tx_input <= 1'h0;
      wake_pulse();
      chk1("oe off", 1'h0, lin_bus_oe);
      chk1("rx off", 1'h1, bus_rx_output);
      rd_chk("wake flag off", `REG_STATUS, 32'h8, 32'h0);
      bus_tx_input <= 1'h1;
      apb(1'h1, `REG_MODE_CTRL, 32'h1);
      wake_pulse();
      chk1("rx after wake", 1'h0, bus_rx_output);
      rd_chk("mode after wake", `REG_MODE_CTRL, 32'h3, 32'h1);
      // permission table, mode write pairs in device modes normal to failsafe
      foreach (rows[i]) begin
         apb(1'h1, `REG_MODE_CTRL, 32'h0);
         device_mode <= rows[i].dev;
         apb(1'h1, `REG_MODE_CTRL, {30'h0, rows[i].first});
         apb(1'h1, `REG_MODE_CTRL, {30'h0, rows[i].second});
         rd_chk("mode row", `REG_MODE_CTRL, 32'h3, {30'h0, rows[i].exp});
      end
      // enabling: early low, back high, then a stale low across the end
      device_mode <= 3'h0;
      apb(1'h1, `REG_MODE_CTRL, 32'h3);
      for (int i = 0; i < 25; i++) begin
         @(posedge clock);
         chk1("oe enabling", 1'h0, lin_bus_oe);
         // last pass lets the host go recessive after the enable end
         bus_tx_input <= (i >= 3 && i < 8) || i == 24;
      end
      cyc(3);
      bus_tx_input <= 1'h0;
      cyc(3);
      chk1("oe dominant", 1'h1, lin_bus_oe);
      chk1("rx dominant", 1'h0, bus_rx_output);
      chk1("bus drive level", 1'h0, lin_bus_out);
      bus_tx_input <= 1'h1;
      cyc(3);
      chk1("oe recessive", 1'h0, lin_bus_oe);
      chk1("rx recessive", 1'h1, bus_rx_output);
      rd_chk("enable done", `REG_STATUS, 32'h4, 32'h4);
      device_mode <= 3'h1;
      rd_chk("normal kept in stop", `REG_MODE_CTRL, 32'h3, 32'h3);
      device_mode <= 3'h2;
      rd_chk("normal left in sleep", `REG_MODE_CTRL, 32'h3, 32'h0);
      // receive only: driver stays off, receiver follows the wire
      device_mode <= 3'h0;
      apb(1'h1, `REG_MODE_CTRL, 32'h2);
      bus_tx_input <= 1'h0;
      pull_dom <= 1'h1;
      cyc(3);
      chk1("oe receive only", 1'h0, lin_bus_oe);
      chk1("rx receive only", 1'h0, bus_rx_output);
      bus_tx_input <= 1'h1;
      pull_dom <= 1'h0;
      // overrun the edge buffer, then drain it dry
      for (int i = 0; i < 40; i++) begin
         cyc(3);
         pull_dom <= ~pull_dom;
      end
      cyc(3);
      rd_chk("count and overflow", `REG_STATUS, 32'hfe0, 32'h820);
      n = 0;
      do begin
         apb(1'h0, `REG_RX_EDGE, 32'h0);
         n += rd[31];
      end while (rd[31] === 1'h1 && n < 40);
      chk("empty edge word", 32'h0, rd);
      chk1("words drained", 1'h1, n >= 32 && n <= 33);
      apb(1'h1, `REG_STATUS, 32'h20);
      rd_chk("overflow cleared", `REG_STATUS, 32'hfe0, 32'h0);
      // unmapped address answers with an error
      apb(1'h0, 12'h00c, 32'h0);
      chk1("unmapped error", 1'h1, err);
      // reset in mid-run returns the transceiver to off
      reset_n <= 1'h0;
      cyc(2);
      reset_n <= 1'h1;
      rd_chk("mode after second reset", `REG_MODE_CTRL, 32'h3, 32'h0);
      chk1("rx after second reset", 1'h1, bus_rx_output);
      chk1("oe after second reset", 1'h0, lin_bus_oe);
      test_done();
   end
endmodule

// ===== verilog/edge_fifo.sv
// edge_fifo.sv: word fifo with registered read data
// assumes the drain pops at most every other cycle
`include "lin_ctrl_map.svh"
module edge_fifo
   import lin_pkg::*;
#(
   parameter int W = 17, // word width
   parameter int DEPTH = `FIFO_DEPTH // words held
) (
   input logic clock, // system clock
   input logic reset_n, // synchronous reset
   stream_if.sink fill, // words in
   stream_if.source drain, // words out
   output logic [$clog2(DEPTH+1)-1:0] count // words stored
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [W-1:0] dout_reg;
   logic valid_reg, valid_next;
   logic push, pop;

   // ************************************************************
   // pointers and count
   // ************************************************************
   // full and empty come from the count, never from the pointers alone
   always_comb begin
      push = fill.valid && (cnt_reg != CW'(DEPTH));
      pop = drain.ready && valid_reg && (cnt_reg != '0);
      wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = CW'(cnt_reg + 1'b1);
      end else if (pop && !push) begin
         cnt_next = CW'(cnt_reg - 1'b1);
      end
      // valid drops for a cycle after a pop so data and flag stay paired
      valid_next = (cnt_reg != '0) && !pop;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
         valid_reg <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg <= cnt_next;
         valid_reg <= valid_next;
      end
   end

   // ************************************************************
   // storage and registered read port
   // ************************************************************
   // storage and read data carry no reset, only pointers, count and valid do
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= fill.data;
      end
      dout_reg <= mem[rd_ptr_reg];
   end

   assign fill.ready = (cnt_reg != CW'(DEPTH));
   assign drain.valid = valid_reg;
   assign drain.data = dout_reg;
   assign count = cnt_reg;
endmodule

// ===== verilog/lin_ctrl.sv
// lin_ctrl.sv: LIN transceiver mode control, bus pin logic, APB registers
// assumes pins synchronous to clock; the bus wire is resolved outside
// Contract
// - transceiver starts off after reset
// - off allowed in every device mode
// - no wake indication while off
// - host picks mode through mode field
// - normal mode entered by write in device normal
// - normal mode only in device normal or stop
// - driver follows host transmit input
// - bus level copied to receive output
// - stale dominant at enable end not sent
// - receive only: driver off, receiver on
// - receive only allowed in device normal or stop
// - wake mode coded 01, kept after wake
//
// Added by the designer: the APB interface to the registers and the register offsets.
`include "lin_ctrl_map.svh"
module lin_ctrl
   import lin_pkg::*;
#(
   parameter int EN_TIME_NS = `EN_TIME_NS, // enabling time
   parameter int WAKE_TIME_NS = `WAKE_TIME_NS, // dominant time for wake
   parameter int FIFO_DEPTH = `FIFO_DEPTH // edge buffer depth
) (
   input logic clock, // 100 MHz system clock
   input logic reset_n, // synchronous reset, active low
   input logic psel, // apb select
   input logic penable, // apb access phase
   input logic pwrite, // apb direction
   input logic [`ADDR_W-1:0] paddr, // apb byte address
   input logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb transfer done
   output logic pslverr, // apb error on unmapped address
   input logic [2:0] device_mode, // device operating mode
   input logic bus_tx_input, // host transmit data, low is dominant
   output logic bus_rx_output, // receive data to host, low is dominant
   input logic lin_bus_in, // bus level, low is dominant
   output logic lin_bus_out, // bus drive level, always low
   output logic lin_bus_oe // high while pulling the bus dominant
);
   localparam int EN_RAW = (EN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int EN_CYCLES = (EN_RAW < 1) ? 1 : EN_RAW;
   localparam int WK_RAW = (WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int WK_CYCLES = (WK_RAW < 1) ? 1 : WK_RAW;
   localparam int EN_W = $clog2(EN_CYCLES + 1);
   localparam int WK_W = $clog2(WK_CYCLES + 1);
   localparam int EDGE_W = `TS_W + 1;
   localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

   // ************************************************************
   // apb slave
   // ************************************************************
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pop_pend_reg, pop_pend_next;
   logic access, done, mapped, wr_mode, wr_status, pop;
   lin_mode_t mode_reg, mode_next;
   logic en_done_reg, wake_reg, ovf_reg;
   logic [CNT_W-1:0] fifo_count;

   stream_if #(.W(EDGE_W)) cap_s ();
   stream_if #(.W(EDGE_W)) rd_s ();

   // one wait state: data loaded in the first access cycle, done in the next
   always_comb begin
      access = psel && penable && !pready_reg;
      done = psel && penable && pready_reg;
      mapped = (paddr == `REG_MODE_CTRL) || (paddr == `REG_STATUS) ||
               (paddr == `REG_RX_EDGE);
      wr_mode = done && pwrite && (paddr == `REG_MODE_CTRL);
      wr_status = done && pwrite && (paddr == `REG_STATUS);
      pready_next = access;
      pslverr_next = access && !mapped;
      // pop decision latched so a word arriving mid-access is not lost
      pop_pend_next = access && !pwrite && (paddr == `REG_RX_EDGE) && rd_s.valid;
      pop = done && pop_pend_reg;
      prdata_next = prdata_reg;
      if (access) begin
         prdata_next = 32'h0;
         if (!pwrite && paddr == `REG_MODE_CTRL) begin
            prdata_next[1:0] = mode_reg;
         end else if (!pwrite && paddr == `REG_STATUS) begin
            prdata_next[1:0] = mode_reg;
            prdata_next[`ST_EN_DONE] = en_done_reg;
            prdata_next[`ST_WAKE] = wake_reg;
            prdata_next[`ST_BUS] = lin_bus_in;
            prdata_next[`ST_OVF] = ovf_reg;
            prdata_next[`ST_CNT_LSB +: CNT_W] = fifo_count;
         end else if (!pwrite && paddr == `REG_RX_EDGE) begin
            // an empty buffer reads as zero, never as a stale word
            if (rd_s.valid) begin
               prdata_next[EDGE_W-1:0] = rd_s.data;
            end
            prdata_next[`EDGE_VALID] = rd_s.valid;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pop_pend_reg <= 1'b0;
      end else begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
         pop_pend_reg <= pop_pend_next;
      end
   end

   // ************************************************************
   // transceiver mode
   // ************************************************************
   logic dev_ns, wr_ok, comm_mode;
   lin_mode_t req;

   // a refused write leaves the mode alone; leaving normal/stop drops normal and receive only to off
   always_comb begin
      req = lin_mode_t'(pwdata[1:0]);
      dev_ns = (device_mode == `DEV_NORMAL) || (device_mode == `DEV_STOP);
      comm_mode = (mode_reg == LIN_NORMAL) || (mode_reg == LIN_RXONLY);
      case (req)
         LIN_OFF: wr_ok = 1'b1;
         LIN_WAKE: wr_ok = (device_mode != 3'(`DEV_FAILSAFE));
         LIN_NORMAL: wr_ok = (device_mode == `DEV_NORMAL);
         LIN_RXONLY: wr_ok = dev_ns;
         default: wr_ok = 1'b0;
      endcase
      mode_next = mode_reg;
      if (wr_mode && wr_ok) begin
         mode_next = req;
      end else if (comm_mode && !dev_ns) begin
         mode_next = LIN_OFF;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mode_reg <= LIN_OFF;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // ************************************************************
   // enabling sequence and bus driver
   // ************************************************************
   logic [EN_W-1:0] en_cnt_reg, en_cnt_next;
   logic en_done_next, armed_reg, armed_next;
   logic oe_reg, oe_next, rx_reg, rx_next;

   // driver waits for the enabling time, then for a recessive input
   always_comb begin
      en_cnt_next = '0;
      en_done_next = 1'b0;
      if (mode_reg == LIN_NORMAL) begin
         en_done_next = en_done_reg;
         en_cnt_next = en_cnt_reg;
         if (!en_done_reg) begin
            en_cnt_next = EN_W'(en_cnt_reg + 1'b1);
            en_done_next = (en_cnt_reg == EN_W'(EN_CYCLES - 1));
         end
      end
      // a low held across the enable end never arms the driver
      armed_next = (mode_reg == LIN_NORMAL) && en_done_reg &&
                   (armed_reg || bus_tx_input);
      oe_next = (mode_reg == LIN_NORMAL) && armed_reg && !bus_tx_input;
      case (mode_reg)
         LIN_OFF: rx_next = 1'b1;
         LIN_WAKE: rx_next = !wake_reg;
         default: rx_next = lin_bus_in;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         en_cnt_reg <= '0;
         en_done_reg <= 1'b0;
         armed_reg <= 1'b0;
         oe_reg <= 1'b0;
         rx_reg <= 1'b1;
      end else begin
         en_cnt_reg <= en_cnt_next;
         en_done_reg <= en_done_next;
         armed_reg <= armed_next;
         oe_reg <= oe_next;
         rx_reg <= rx_next;
      end
   end

   // ************************************************************
   // wake pattern detector
   // ************************************************************
   wake_state_t wk_reg, wk_next;
   logic [WK_W-1:0] wk_cnt_reg, wk_cnt_next;
   logic bus_prev_reg, wake_next, wake_set;

   // falling edge, long dominant, then rising edge; only in wake mode
   always_comb begin
      wk_next = wk_reg;
      wk_cnt_next = wk_cnt_reg;
      wake_set = 1'b0;
      if (mode_reg != LIN_WAKE || wake_reg) begin
         wk_next = WK_IDLE;
         wk_cnt_next = '0;
      end else begin
         case (wk_reg)
            WK_IDLE: begin
               wk_cnt_next = '0;
               if (bus_prev_reg && !lin_bus_in) begin
                  wk_next = WK_DOM;
               end
            end
            WK_DOM: begin
               wk_cnt_next = WK_W'(wk_cnt_reg + 1'b1);
               if (lin_bus_in) begin
                  wk_next = WK_IDLE;
               end else if (wk_cnt_reg == WK_W'(WK_CYCLES - 1)) begin
                  wk_next = WK_LONG;
               end
            end
            WK_LONG: begin
               if (lin_bus_in) begin
                  wake_set = 1'b1;
                  wk_next = WK_IDLE;
               end
            end
            default: wk_next = WK_IDLE;
         endcase
      end
      // flag means "woken in wake mode", so leaving the mode clears it
      wake_next = (mode_next != mode_reg) ? 1'b0 : (wake_reg || wake_set);
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wk_reg <= WK_IDLE;
         wk_cnt_reg <= '0;
         bus_prev_reg <= 1'b1;
         wake_reg <= 1'b0;
      end else begin
         wk_reg <= wk_next;
         wk_cnt_reg <= wk_cnt_next;
         bus_prev_reg <= lin_bus_in;
         wake_reg <= wake_next;
      end
   end

   // ************************************************************
   // bus edge capture into the fifo
   // ************************************************************
   logic [`TS_W-1:0] ts_reg, ts_next;
   logic cap_v_reg, cap_v_next, ovf_next, edge_seen;
   logic [EDGE_W-1:0] cap_d_reg, cap_d_next;

   // one pending word; a full fifo stalls it and further edges count as overflow
   always_comb begin
      ts_next = `TS_W'(ts_reg + 1'b1);
      edge_seen = comm_mode && (lin_bus_in != bus_prev_reg);
      cap_v_next = cap_v_reg && !cap_s.ready;
      cap_d_next = cap_d_reg;
      ovf_next = ovf_reg;
      if (wr_status && pwdata[`ST_OVF]) begin
         ovf_next = 1'b0;
      end
      if (edge_seen) begin
         if (cap_v_next) begin
            ovf_next = 1'b1; // set wins over the clear
         end else begin
            cap_v_next = 1'b1;
            cap_d_next = {lin_bus_in, ts_reg};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ts_reg <= '0;
         cap_v_reg <= 1'b0;
         cap_d_reg <= '0;
         ovf_reg <= 1'b0;
      end else begin
         ts_reg <= ts_next;
         cap_v_reg <= cap_v_next;
         cap_d_reg <= cap_d_next;
         ovf_reg <= ovf_next;
      end
   end

   assign cap_s.valid = cap_v_reg;
   assign cap_s.data = cap_d_reg;
   assign rd_s.ready = pop;

   edge_fifo #(.W(EDGE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .reset_n(reset_n),
      .fill(cap_s),
      .drain(rd_s),
      .count(fifo_count)
   );

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign bus_rx_output = rx_reg;
   assign lin_bus_oe = oe_reg;
   assign lin_bus_out = 1'b0;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   AST_RESET_OFF: assert property (disable iff (1'b0)
      !reset_n |=> (mode_reg == LIN_OFF) && !lin_bus_oe && bus_rx_output)
      else $error("not off after reset");
   AST_OFF_ANYTIME: assert property (
      (wr_mode && pwdata[1:0] == `MODE_OFF) |=> mode_reg == LIN_OFF)
      else $error("off write not taken");
   AST_OFF_NO_WAKE: assert property (
      (mode_reg == LIN_OFF) |=> !wake_reg)
      else $error("wake flagged while off");
   AST_MODE_WRITE: assert property (
      (wr_mode && wr_ok) |=> mode_reg == $past(pwdata[1:0]))
      else $error("permitted mode write lost");
   AST_NORMAL_ENTRY: assert property (
      $rose(mode_reg == LIN_NORMAL) |-> $past(device_mode) == `DEV_NORMAL)
      else $error("normal mode entered outside device normal");
   AST_DEV_LEAVE: assert property (
      !dev_ns |=> !(mode_reg == LIN_NORMAL || mode_reg == LIN_RXONLY))
      else $error("communication mode outside normal or stop");
   AST_TX_FOLLOW: assert property (
      (mode_reg == LIN_NORMAL && armed_reg) |=> lin_bus_oe == !$past(bus_tx_input))
      else $error("driver does not follow transmit input");
   AST_RX_FOLLOW: assert property (
      (mode_reg == LIN_NORMAL || mode_reg == LIN_RXONLY) |=>
      bus_rx_output == $past(lin_bus_in))
      else $error("receive output does not follow bus");
   AST_STALE_DOM: assert property (
      (mode_reg == LIN_NORMAL && !armed_reg) |=> !lin_bus_oe)
      else $error("driven before arming");
   AST_ARM_HIGH: assert property (
      $rose(armed_reg) |-> $past(bus_tx_input && en_done_reg))
      else $error("armed without recessive input after enabling");
   AST_RXONLY_QUIET: assert property (
      (mode_reg == LIN_RXONLY) |=> !lin_bus_oe)
      else $error("driver on in receive only");
   AST_WAKE_CODE: assert property (
      $rose(wake_reg) |-> (mode_reg == `MODE_WAKE) ##1 !bus_rx_output)
      else $error("wake not shown as code 01 with receive low");
   AST_REFUSED: assert property (
      (wr_mode && !wr_ok && dev_ns) |=> $stable(mode_reg))
      else $error("refused write changed mode");
   AST_OFF_QUIET: assert property (
      (mode_reg == LIN_OFF) |=> !lin_bus_oe && bus_rx_output)
      else $error("off state not quiet");
endmodule

// ===== verilog/lin_ctrl_map.svh
// lin_ctrl_map.svh: register offsets, field positions, codes and times
// assumes inclusion by bare name from the package and the modules
`ifndef LIN_CTRL_MAP_SVH
`define LIN_CTRL_MAP_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define REG_MODE_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_RX_EDGE 12'h008
`define ADDR_W 12
// ************************************************************
// transceiver mode codes and device operating modes
// ************************************************************
`define MODE_OFF 2'h0
`define MODE_WAKE 2'h1
`define MODE_NORMAL 2'h3
`define MODE_RXONLY 2'h2
`define DEV_NORMAL 3'h0
`define DEV_STOP 3'h1
`define DEV_SLEEP 3'h2
`define DEV_RESTART 3'h3
`define DEV_FAILSAFE 3'h4
// ************************************************************
// status and edge word fields
// ************************************************************
`define ST_EN_DONE 2
`define ST_WAKE 3
`define ST_BUS 4
`define ST_OVF 5
`define ST_CNT_LSB 6
`define EDGE_VALID 31
`define TS_W 16
// ************************************************************
// times and clock
// ************************************************************
`define CLK_PERIOD_NS 10
`define EN_TIME_NS 30000
`define WAKE_TIME_NS 30000
`define FIFO_DEPTH 32
`endif

// ===== verilog/lin_pkg.sv
// lin_pkg.sv: types shared by the transceiver control modules
// assumes the map header is found on the include path
package lin_pkg;
`include "lin_ctrl_map.svh"
   // transceiver mode, gray order off, wake, normal, receive only
   typedef enum logic [1:0] {
      LIN_OFF = `MODE_OFF,
      LIN_WAKE = `MODE_WAKE,
      LIN_NORMAL = `MODE_NORMAL,
      LIN_RXONLY = `MODE_RXONLY
   } lin_mode_t;
   // wake pattern detector states
   typedef enum logic [1:0] {
      WK_IDLE = 2'h0,
      WK_DOM = 2'h1,
      WK_LONG = 2'h3
   } wake_state_t;
endpackage

// ===== verilog/stream_if.sv
// stream_if.sv: valid/ready word stream between the design's modules
// assumes both ends share one clock
interface stream_if #(
   parameter int W = 17
);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface
